//--- orp_defs.svh
`ifndef ORP_DEFS_SVH
`define ORP_DEFS_SVH

// Register addresses
`define ORP_ADDR_RST 8'h00
`define ORP_ADDR_PDN 8'h0F
`define ORP_ADDR_LVDS 8'h11
`define ORP_ADDR_TERM 8'h12
`define ORP_ADDR_LFNS 8'h14
`define ORP_ADDR_INV 8'h24
`define ORP_ADDR_GAIN_A 8'h2A
`define ORP_ADDR_GAIN_B 8'h2B
`define ORP_ADDR_CLK 8'h42
`define ORP_ADDR_FMT 8'h46

// Field positions
`define ORP_BIT_RST 0
`define ORP_BIT_PARTIAL 8
`define ORP_BIT_FULL 9
`define ORP_BIT_PINSEL 10
`define ORP_BIT_DIFF 0
`define ORP_BIT_DCC 2
`define ORP_BIT_VCM 3
`define ORP_BIT_PHASE 5
`define ORP_BIT_BTC 2
`define ORP_BIT_MSB 3
`define ORP_BIT_SDR 4
`define ORP_BIT_FALL 13
`define ORP_BIT_TERM_EN 14
`define ORP_BIT_DRV_CLK 0
`define ORP_BIT_DRV_FRM 4
`define ORP_BIT_DRV_DAT 8

// Reset values and limits
`define ORP_RST_WORD 16'h0000
`define ORP_RST_BYTE 8'h00
`define ORP_RST_DRV 3'h0
`define ORP_GAIN_MAX 4'hC

// Serial frame and timing
`define ORP_FRAME_BITS 24
`define ORP_WAKE_NS 50000
`define ORP_CLK_MHZ 40
`define ORP_WAKE_CYC ((`ORP_WAKE_NS * `ORP_CLK_MHZ + 999) / 1000)
`endif

//--- orp_pkg.sv
package orp_pkg;
   typedef enum logic [1:0] {ORP_AWAKE, ORP_PARTIAL, ORP_FULL} orp_pwr_t;
endpackage

//--- orp_wr_if.sv
`timescale 1ns/100ps
`default_nettype none
interface orp_wr_if;
   logic wr;
   logic [7:0] addr;
   logic [15:0] data;
   modport src (output wr, output addr, output data);
   modport dst (input wr, input addr, input data);
endinterface
`default_nettype wire

//--- orp_ser_rx.sv
`timescale 1ns/100ps
`default_nettype none
`include "orp_defs.svh"
module orp_ser_rx (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire logic ce_in,
   input wire logic sen_n_in,
   input wire logic sclk_in,
   input wire logic sdata_in,
   orp_wr_if.src wr_port
);
   import orp_pkg::*;

   typedef struct packed {
      logic [1:0] sen_s;
      logic [1:0] sclk_s;
      logic [1:0] sdat_s;
      logic sclk_d;
      logic sen_d;
      logic [23:0] shift;
      logic [4:0] cnt;
      logic wr;
      logic [7:0] addr;
      logic [15:0] data;
   } orp_rx_t;

   orp_rx_t st_reg, st_next;

   // -----------------------------------------
   // Frame capture
   // -----------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.wr = 1'b0;
      st_next.sen_s = {st_reg.sen_s[0], sen_n_in};
      st_next.sclk_s = {st_reg.sclk_s[0], sclk_in};
      st_next.sdat_s = {st_reg.sdat_s[0], sdata_in};
      st_next.sclk_d = st_reg.sclk_s[1];
      st_next.sen_d = st_reg.sen_s[1];
      if (st_reg.sen_s[1]) begin
         st_next.cnt = 5'h00;
      end else if (st_reg.sclk_s[1] && !st_reg.sclk_d) begin
         st_next.shift = {st_reg.shift[22:0], st_reg.sdat_s[1]};
         if (st_reg.cnt != 5'h1F) begin
            st_next.cnt = st_reg.cnt + 5'h01;
         end
      end
      // Frame ends on enable release with exactly a full word
      if (st_reg.sen_s[1] && !st_reg.sen_d && st_reg.cnt == 5'(`ORP_FRAME_BITS)) begin
         st_next.wr = 1'b1;
         st_next.addr = st_reg.shift[23:16];
         st_next.data = st_reg.shift[15:0];
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         st_reg <= '{sen_s: 2'h3, sen_d: 1'b1, default: '0};
      end else if (ce_in) begin
         st_reg <= st_next;
      end
   end

   assign wr_port.wr = st_reg.wr;
   assign wr_port.addr = st_reg.addr;
   assign wr_port.data = st_reg.data;
endmodule
`default_nettype wire

//--- orp_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "orp_defs.svh"
module orp_ctrl #(
   parameter int WAKE_CYC = `ORP_WAKE_CYC
) (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire logic ce_in,
   input wire logic sen_n_in,
   input wire logic sclk_in,
   input wire logic sdata_in,
   input wire logic sleep_pin_in,
   output logic [7:0] channel_sleep_bits_out,
   output logic partial_sleep_bit_out,
   output logic full_sleep_bit_out,
   output logic sleep_pin_select_out,
   output orp_pkg::orp_pwr_t power_state_out,
   output logic [7:0] channel_off_out,
   output logic fast_wake_ok_out,
   output logic soft_reset_out,
   output logic diff_clk_out,
   output logic dcc_en_out,
   output logic vcm_ref_out,
   output logic [1:0] ddr_phase_out,
   output logic twos_complement_coding_out,
   output logic msb_first_out,
   output logic sdr_out,
   output logic sdr_fall_out,
   output logic [31:0] gain_out,
   output logic [7:0] input_swap_out,
   output logic [7:0] lfns_out,
   output logic [2:0] drv_clk_out,
   output logic [2:0] drv_frame_out,
   output logic [2:0] drv_data_out,
   output logic term_en_out,
   output logic [2:0] term_clk_out,
   output logic [2:0] term_frame_out,
   output logic [2:0] term_data_out
);
   import orp_pkg::*;

   initial begin
      if (WAKE_CYC < 1 || WAKE_CYC > 65535) begin
         $error("WAKE_CYC out of range");
      end
   end

   typedef struct packed {
      logic [1:0] pin_s;
      logic [7:0] ch_sleep;
      logic partial_bit;
      logic full_bit;
      logic pin_sel;
      orp_pwr_t pwr;
      logic [7:0] ch_off;
      logic [15:0] wake_cnt;
      logic fast_ok;
      logic srst;
      logic diff_clk;
      logic dcc;
      logic vcm;
      logic [1:0] phase;
      logic twos_complement_coding;
      logic msb;
      logic sdr;
      logic fall;
      logic [31:0] gain;
      logic [7:0] swap;
      logic [7:0] lfns;
      logic [2:0] drv_clk;
      logic [2:0] drv_frm;
      logic [2:0] drv_dat;
      logic term_en;
      logic [2:0] term_clk;
      logic [2:0] term_frm;
      logic [2:0] term_dat;
   } orp_st_t;

   localparam orp_st_t ST_RESET = '{
      pwr: ORP_AWAKE,
      drv_clk: `ORP_RST_DRV,
      drv_frm: `ORP_RST_DRV,
      drv_dat: `ORP_RST_DRV,
      default: '0
   };

   orp_st_t st_reg, st_next;
   orp_wr_if wbus ();

   // -----------------------------------------
   // Serial programming port
   // -----------------------------------------
   orp_ser_rx u_rx (
      .mclk_in(mclk_in),
      .reset_n_in(reset_n_in),
      .ce_in(ce_in),
      .sen_n_in(sen_n_in),
      .sclk_in(sclk_in),
      .sdata_in(sdata_in),
      .wr_port(wbus.src)
   );

   // Gain code limited to the 12dB top step
   function automatic logic [3:0] clamp_gain(input logic [3:0] g);
      clamp_gain = (g > `ORP_GAIN_MAX) ? `ORP_GAIN_MAX : g;
   endfunction

   logic [15:0] wd;
   logic pin_hi;
   logic go_full;
   logic go_part;
   assign wd = wbus.data;
   assign pin_hi = st_reg.pin_s[1];

   // -----------------------------------------
   // Next state
   // -----------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.srst = 1'b0;
      st_next.pin_s = {st_reg.pin_s[0], sleep_pin_in};
      if (wbus.wr) begin
         case (wbus.addr)
            `ORP_ADDR_RST: begin
               if (wd[`ORP_BIT_RST]) begin
                  st_next = ST_RESET;
                  st_next.pin_s = {st_reg.pin_s[0], sleep_pin_in};
                  st_next.srst = 1'b1;
               end
            end
            `ORP_ADDR_PDN: begin
               st_next.ch_sleep = wd[7:0];
               st_next.partial_bit = wd[`ORP_BIT_PARTIAL];
               st_next.full_bit = wd[`ORP_BIT_FULL];
               st_next.pin_sel = wd[`ORP_BIT_PINSEL];
            end
            `ORP_ADDR_LVDS: begin
               st_next.drv_clk = wd[`ORP_BIT_DRV_CLK +: 3];
               st_next.drv_frm = wd[`ORP_BIT_DRV_FRM +: 3];
               st_next.drv_dat = wd[`ORP_BIT_DRV_DAT +: 3];
            end
            `ORP_ADDR_TERM: begin
               st_next.term_en = wd[`ORP_BIT_TERM_EN];
               st_next.term_clk = wd[`ORP_BIT_DRV_CLK +: 3];
               st_next.term_frm = wd[`ORP_BIT_DRV_FRM +: 3];
               st_next.term_dat = wd[`ORP_BIT_DRV_DAT +: 3];
            end
            `ORP_ADDR_LFNS: begin
               st_next.lfns = wd[7:0];
            end
            `ORP_ADDR_INV: begin
               st_next.swap = wd[7:0];
            end
            `ORP_ADDR_GAIN_A: begin
               st_next.gain[3:0] = clamp_gain(wd[3:0]);
               st_next.gain[7:4] = clamp_gain(wd[7:4]);
               st_next.gain[11:8] = clamp_gain(wd[11:8]);
               st_next.gain[15:12] = clamp_gain(wd[15:12]);
            end
            `ORP_ADDR_GAIN_B: begin
               st_next.gain[19:16] = clamp_gain(wd[15:12]);
               st_next.gain[23:20] = clamp_gain(wd[11:8]);
               st_next.gain[27:24] = clamp_gain(wd[7:4]);
               st_next.gain[31:28] = clamp_gain(wd[3:0]);
            end
            `ORP_ADDR_CLK: begin
               st_next.diff_clk = wd[`ORP_BIT_DIFF];
               st_next.dcc = wd[`ORP_BIT_DCC];
               st_next.vcm = wd[`ORP_BIT_VCM];
               st_next.phase = wd[`ORP_BIT_PHASE +: 2];
            end
            `ORP_ADDR_FMT: begin
               st_next.twos_complement_coding = wd[`ORP_BIT_BTC];
               st_next.msb = wd[`ORP_BIT_MSB];
               st_next.sdr = wd[`ORP_BIT_SDR];
               st_next.fall = wd[`ORP_BIT_FALL];
            end
            default: begin
            end
         endcase
      end

      // -----------------------------------------
      // Global power state
      // -----------------------------------------
      go_full = st_reg.full_bit || (pin_hi && !st_reg.pin_sel);
      go_part = st_reg.partial_bit || (pin_hi && st_reg.pin_sel);
      case (st_reg.pwr)
         ORP_AWAKE: begin
            if (go_full) begin
               st_next.pwr = ORP_FULL;
            end else if (go_part) begin
               st_next.pwr = ORP_PARTIAL;
            end
         end
         ORP_PARTIAL: begin
            if (go_full) begin
               st_next.pwr = ORP_FULL;
            end else if (!go_part) begin
               st_next.pwr = ORP_AWAKE;
            end
         end
         ORP_FULL: begin
            if (!go_full) begin
               st_next.pwr = go_part ? ORP_PARTIAL : ORP_AWAKE;
            end
         end
         default: begin
            st_next.pwr = ORP_AWAKE;
         end
      endcase

      // Clock run time in partial power-down, for fast recovery
      if (st_reg.pwr == ORP_PARTIAL) begin
         if (st_reg.wake_cnt < 16'(WAKE_CYC)) begin
            st_next.wake_cnt = st_reg.wake_cnt + 16'h0001;
         end
      end else begin
         st_next.wake_cnt = 16'h0000;
      end
      st_next.fast_ok = (st_reg.pwr == ORP_PARTIAL) &&
                        (st_reg.wake_cnt >= 16'(WAKE_CYC));

      // Soft reset clears power status too; the pin acts again next cycle
      if (st_next.srst) begin
         st_next.pwr = ORP_AWAKE;
         st_next.wake_cnt = 16'h0000;
         st_next.fast_ok = 1'b0;
      end

      st_next.ch_off = (st_next.pwr == ORP_AWAKE) ? st_next.ch_sleep : 8'hFF;
   end

   // -----------------------------------------
   // State register
   // -----------------------------------------
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         st_reg <= ST_RESET;
      end else if (ce_in) begin
         st_reg <= st_next;
      end
   end

   // -----------------------------------------
   // Outputs
   // -----------------------------------------
   assign channel_sleep_bits_out = st_reg.ch_sleep;
   assign partial_sleep_bit_out = st_reg.partial_bit;
   assign full_sleep_bit_out = st_reg.full_bit;
   assign sleep_pin_select_out = st_reg.pin_sel;
   assign power_state_out = st_reg.pwr;
   assign channel_off_out = st_reg.ch_off;
   assign fast_wake_ok_out = st_reg.fast_ok;
   assign soft_reset_out = st_reg.srst;
   assign diff_clk_out = st_reg.diff_clk;
   assign dcc_en_out = st_reg.dcc;
   assign vcm_ref_out = st_reg.vcm;
   assign ddr_phase_out = st_reg.phase;
   assign twos_complement_coding_out = st_reg.twos_complement_coding;
   assign msb_first_out = st_reg.msb;
   assign sdr_out = st_reg.sdr;
   assign sdr_fall_out = st_reg.fall;
   assign gain_out = st_reg.gain;
   assign input_swap_out = st_reg.swap;
   assign lfns_out = st_reg.lfns;
   assign drv_clk_out = st_reg.drv_clk;
   assign drv_frame_out = st_reg.drv_frm;
   assign drv_data_out = st_reg.drv_dat;
   assign term_en_out = st_reg.term_en;
   assign term_clk_out = st_reg.term_clk;
   assign term_frame_out = st_reg.term_frm;
   assign term_data_out = st_reg.term_dat;
endmodule
`default_nettype wire

//--- orp_ctrl_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "orp_defs.svh"
module orp_ctrl_chk #(
   parameter int WAKE_CYC = `ORP_WAKE_CYC
) (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire logic ce_in,
   input wire logic sleep_pin_in,
   input wire logic [7:0] channel_sleep_bits_out,
   input wire logic partial_sleep_bit_out,
   input wire logic full_sleep_bit_out,
   input wire logic sleep_pin_select_out,
   input wire orp_pkg::orp_pwr_t power_state_out,
   input wire logic [7:0] channel_off_out,
   input wire logic fast_wake_ok_out,
   input wire logic soft_reset_out,
   input wire logic diff_clk_out,
   input wire logic [31:0] gain_out,
   input wire logic [2:0] drv_data_out
);
   import orp_pkg::*;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!reset_n_in || !ce_in);
   // ----------------------------------------
   // Cycles spent in partial power-down
   // ----------------------------------------
   logic [15:0] part_cnt_reg;
   logic gain_ok;
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in || power_state_out != ORP_PARTIAL) begin
         part_cnt_reg <= 16'h0000;
      end else if (ce_in && part_cnt_reg != 16'hFFFF) begin
         part_cnt_reg <= part_cnt_reg + 16'h0001;
      end
   end
   always_comb begin
      gain_ok = 1'b1;
      for (int k = 0; k < 8; k++) begin
         if (gain_out[4*k +: 4] > 4'hC) begin
            gain_ok = 1'b0;
         end
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   chk_off_sleep: assert property ($stable(power_state_out) && power_state_out != ORP_AWAKE
      |-> channel_off_out == 8'hFF) else $error("channels not all off in sleep");
   chk_off_awake: assert property ($stable(power_state_out) && $stable(channel_sleep_bits_out)
      && power_state_out == ORP_AWAKE |-> channel_off_out == channel_sleep_bits_out)
      else $error("channel off mismatch");
   chk_full_bit: assert property (full_sleep_bit_out [*3] |-> power_state_out == ORP_FULL)
      else $error("full sleep bit ignored");
   chk_partial_bit: assert property ((partial_sleep_bit_out && !full_sleep_bit_out
      && !sleep_pin_in) [*6] |-> power_state_out == ORP_PARTIAL) else $error("partial ignored");
   chk_pin_full: assert property ((sleep_pin_in && !sleep_pin_select_out) [*6]
      |-> power_state_out == ORP_FULL) else $error("pin full sleep ignored");
   chk_pin_partial: assert property ((sleep_pin_in && sleep_pin_select_out
      && !full_sleep_bit_out) [*6] |-> power_state_out == ORP_PARTIAL)
      else $error("pin partial sleep ignored");
   chk_stay_awake: assert property ((!sleep_pin_in && !partial_sleep_bit_out
      && !full_sleep_bit_out) [*6] |-> power_state_out == ORP_AWAKE) else $error("not awake");
   chk_soft_clear: assert property (soft_reset_out |-> ##[0:1] (channel_sleep_bits_out == 8'h00
      && gain_out == 32'h0000_0000 && !diff_clk_out && drv_data_out == 3'h0
      && power_state_out == ORP_AWAKE && !fast_wake_ok_out))
      else $error("soft reset left state");
   chk_pulse_once: assert property (soft_reset_out |=> !soft_reset_out)
      else $error("soft reset pulse too long");
   chk_wake_early: assert property (fast_wake_ok_out && power_state_out == ORP_PARTIAL
      |-> part_cnt_reg >= WAKE_CYC) else $error("fast wake too early");
   chk_wake_late: assert property (part_cnt_reg == WAKE_CYC + 4 |-> fast_wake_ok_out)
      else $error("fast wake missing");
   chk_wake_drop: assert property (fast_wake_ok_out && power_state_out != ORP_PARTIAL
      |-> $past(power_state_out) == ORP_PARTIAL) else $error("fast wake held");
   chk_gain_clamp: assert property (gain_ok) else $error("gain above limit");
   cover property (power_state_out == ORP_FULL);
   cover property (power_state_out == ORP_PARTIAL);
   cover property (fast_wake_ok_out);
   cover property (soft_reset_out);
endmodule
bind orp_ctrl orp_ctrl_chk #(.WAKE_CYC(WAKE_CYC)) u_orp_ctrl_chk (.mclk_in(mclk_in),
   .reset_n_in(reset_n_in), .ce_in(ce_in), .sleep_pin_in(sleep_pin_in),
   .channel_sleep_bits_out(channel_sleep_bits_out), .partial_sleep_bit_out(partial_sleep_bit_out),
   .full_sleep_bit_out(full_sleep_bit_out), .sleep_pin_select_out(sleep_pin_select_out),
   .power_state_out(power_state_out), .channel_off_out(channel_off_out),
   .fast_wake_ok_out(fast_wake_ok_out), .soft_reset_out(soft_reset_out),
   .diff_clk_out(diff_clk_out), .gain_out(gain_out), .drv_data_out(drv_data_out));
`default_nettype wire

//--- orp_host.sv
`timescale 1ns/100ps
`default_nettype none
module orp_host (
   input wire logic mclk_in,
   output logic sen_n_out,
   output logic sclk_out,
   output logic sdata_out
);
   initial begin
      sen_n_out = 1'b1;
      sclk_out = 1'b0;
      sdata_out = 1'b0;
   end
   // Whole register in one frame, data bits sent as given, MSB first
   task automatic write(input logic [7:0] addr, input logic [15:0] data);
      logic [23:0] frame;
      frame = {addr, data};
      @(posedge mclk_in) sen_n_out <= 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdata_out <= frame[i];
         repeat (4) @(posedge mclk_in);
         sclk_out <= 1'b1;
         repeat (4) @(posedge mclk_in);
         sclk_out <= 1'b0;
      end
      repeat (4) @(posedge mclk_in);
      sen_n_out <= 1'b1;
      sdata_out <= ~frame[0];
      repeat (4) @(posedge mclk_in);
   endtask
endmodule
`default_nettype wire

//--- test_octal_adc_reset_powerdown_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module test_octal_adc_reset_powerdown_ctrl;
   import orp_pkg::*;
   localparam int WAKE = 20;
   logic mclk_in = 1'b0;
   logic reset_n_in, ce_in, sleep_pin_in, sen_n, sclk, sdata;
   logic [7:0] channel_sleep_bits_out, channel_off_out, input_swap_out, lfns_out;
   logic partial_sleep_bit_out, full_sleep_bit_out, sleep_pin_select_out, fast_wake_ok_out;
   logic soft_reset_out, diff_clk_out, dcc_en_out, vcm_ref_out;
   logic twos_complement_coding_out, msb_first_out, sdr_out;
   logic [31:0] gain_out;
   logic [2:0] drv_clk_out, drv_frame_out, drv_data_out;
   logic [1:0] ddr_phase_out;
   logic sdr_fall_out, term_en_out;
   logic [2:0] term_clk_out, term_frame_out, term_data_out;
   int srst_cnt = 0;
   orp_pwr_t power_state_out;
   int error_cnt = 0;
   int n_compared = 0;
   always #12.5 mclk_in = ~mclk_in;
   // Soft reset pulses seen
   always @(posedge mclk_in) begin
      if (soft_reset_out === 1'b1) begin
         srst_cnt++;
      end
   end
   orp_host u_orp_host (.mclk_in(mclk_in), .sen_n_out(sen_n), .sclk_out(sclk), .sdata_out(sdata));
   orp_ctrl #(.WAKE_CYC(WAKE)) u_orp_ctrl (.mclk_in, .reset_n_in, .ce_in, .sen_n_in(sen_n),
      .sclk_in(sclk), .sdata_in(sdata), .sleep_pin_in, .channel_sleep_bits_out,
      .partial_sleep_bit_out, .full_sleep_bit_out, .sleep_pin_select_out, .power_state_out,
      .channel_off_out, .fast_wake_ok_out, .soft_reset_out, .diff_clk_out, .dcc_en_out,
      .vcm_ref_out, .ddr_phase_out, .twos_complement_coding_out, .msb_first_out, .sdr_out,
      .sdr_fall_out, .gain_out, .input_swap_out, .lfns_out, .drv_clk_out, .drv_frame_out,
      .drv_data_out, .term_en_out, .term_clk_out, .term_frame_out, .term_data_out);
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] addr, input logic [15:0] data);
      u_orp_host.write(addr, data);
      repeat (6) @(posedge mclk_in);
      #1;
   endtask
   task automatic pin(input logic level);
      @(posedge mclk_in) sleep_pin_in <= level;
      repeat (8) @(posedge mclk_in);
      #1;
   endtask
   task automatic end_of_test();
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      reset_n_in = 1'b0;
      ce_in = 1'b1;
      sleep_pin_in = 1'b0;
      repeat (5) @(posedge mclk_in);
      reset_n_in <= 1'b1;
      repeat (4) @(posedge mclk_in);
      #1;
      check({diff_clk_out, dcc_en_out, vcm_ref_out}, 32'h0);
      check({twos_complement_coding_out, msb_first_out, sdr_out}, 32'h0);
      check(gain_out, 32'h0);
      check({input_swap_out, lfns_out}, 32'h0);
      check({drv_clk_out, drv_frame_out, drv_data_out}, 32'h0);
      check(power_state_out, ORP_AWAKE);
      check({ddr_phase_out, sdr_fall_out, term_en_out, term_clk_out}, 32'h0);
      check({term_frame_out, term_data_out, soft_reset_out, fast_wake_ok_out}, 32'h0);
      $display("test defaults done");
      for (int n = 0; n < 8; n++) begin
         wr(8'h0F, 16'h0001 << n);
         check(channel_off_out, 32'h1 << n);
         check(power_state_out, ORP_AWAKE);
      end
      $display("test channel sleep done");
      wr(8'h0F, 16'h0100);
      check(power_state_out, ORP_PARTIAL);
      check(channel_off_out, 32'hFF);
      check(fast_wake_ok_out, 32'h0);
      repeat (WAKE) @(posedge mclk_in);
      #1;
      check(fast_wake_ok_out, 32'h1);
      wr(8'h0F, 16'h0300);
      check({sleep_pin_select_out, full_sleep_bit_out, partial_sleep_bit_out}, 32'h3);
      check(power_state_out, ORP_FULL);
      check(fast_wake_ok_out, 32'h0);
      $display("test register sleep done");
      wr(8'h0F, 16'h0000);
      check(power_state_out, ORP_AWAKE);
      pin(1'b1);
      check(power_state_out, ORP_FULL);
      pin(1'b0);
      wr(8'h0F, 16'h0400);
      check(sleep_pin_select_out, 32'h1);
      pin(1'b1);
      check(power_state_out, ORP_PARTIAL);
      pin(1'b0);
      check(power_state_out, ORP_AWAKE);
      $display("test sleep pin done");
      wr(8'h42, 16'h806D);
      check({diff_clk_out, dcc_en_out, vcm_ref_out}, 32'h7);
      check(ddr_phase_out, 32'h3);
      wr(8'h46, 16'hA21C);
      check({twos_complement_coding_out, msb_first_out, sdr_out}, 32'h7);
      check(sdr_fall_out, 32'h1);
      wr(8'h24, 16'h00FF);
      check(input_swap_out, 32'hFF);
      wr(8'h14, 16'h0081);
      check(lfns_out, 32'h81);
      wr(8'h11, 16'h0521);
      check({drv_clk_out, drv_frame_out, drv_data_out}, 32'h055);
      wr(8'h12, 16'h4521);
      check({term_en_out, term_clk_out, term_frame_out, term_data_out}, 32'h255);
      wr(8'h2A, 16'hC90F);
      wr(8'h2B, 16'h1234);
      check(gain_out, 32'h4321_C90C);
      $display("test configuration done");
      wr(8'h0F, 16'h00A5);
      wr(8'h00, 16'h0001);
      check(gain_out, 32'h0);
      check({diff_clk_out, twos_complement_coding_out, input_swap_out}, 32'h0);
      check({channel_sleep_bits_out, drv_data_out}, 32'h0);
      check(power_state_out, ORP_AWAKE);
      check({dcc_en_out, vcm_ref_out, msb_first_out, sdr_out, sdr_fall_out}, 32'h0);
      check({ddr_phase_out, lfns_out, drv_clk_out, drv_frame_out}, 32'h0);
      check({term_en_out, term_clk_out, term_frame_out, term_data_out}, 32'h0);
      check({partial_sleep_bit_out, full_sleep_bit_out, sleep_pin_select_out}, 32'h0);
      check({channel_off_out, fast_wake_ok_out, soft_reset_out}, 32'h0);
      check(srst_cnt, 32'h1);
      $display("test soft reset done");
      @(posedge mclk_in) ce_in <= 1'b0;
      pin(1'b1);
      check(power_state_out, ORP_AWAKE);
      @(posedge mclk_in) ce_in <= 1'b1;
      repeat (6) @(posedge mclk_in);
      #1;
      check(power_state_out, ORP_FULL);
      pin(1'b0);
      check(power_state_out, ORP_AWAKE);
      $display("test clock enable done");
      end_of_test();
   end
   initial begin
      repeat (20000) @(posedge mclk_in);
      error_cnt++;
      $display("Error at %0t: watchdog expired", $time);
      end_of_test();
   end
endmodule
`default_nettype wire
